/* hdl/egress_sched_pkg.sv */
// constants, register map and types for the egress queue scheduler
package egress_sched_pkg;
	localparam int NUM_Q     = 8;
	localparam int QW        = 3;
	localparam int WEIGHT_W  = 8;
	localparam int LEN_W     = 14;
	localparam int MAX_FRAME = 9720;
	localparam int BYTE_UNIT = 256;
	localparam int CREDIT_W  = 18;
	localparam int OCC_W     = 24;
	localparam int NUM_IN    = 6;
	localparam int NUM_OPT   = 6;
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_WEIGHT_LO = 8'h04;
	localparam logic [7:0] ADDR_WEIGHT_HI = 8'h08;
	localparam logic [7:0] ADDR_STATUS    = 8'h0C;
	localparam logic [7:0] ADDR_CPU_MAP   = 8'h10;
	localparam logic [7:0] ADDR_TC2COS    = 8'h14;
	localparam logic [7:0] ADDR_QOCC_BASE = 8'h20;
	localparam logic [7:0] ADDR_IN_BASE   = 8'h40;
	// control and status fields
	localparam int CTRL_OPT_LSB   = 0;
	localparam int CTRL_BYTE_BIT  = 3;
	localparam int CTRL_BURST_BIT = 4;
	localparam int CTRL_AGG_BIT   = 5;
	localparam int STAT_BUSY_BIT  = 0;
	localparam int STAT_PTR_LSB   = 1;
	localparam int STAT_MASK_LSB  = 8;
	// reset values
	localparam logic [5:0]  CTRL_RST    = 6'h00;
	localparam logic [31:0] WEIGHT_RST  = 32'h0101_0101;
	localparam logic [23:0] MAP_RST     = 24'hFA_C688;
	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT, ST_POST} state_t;
endpackage

/* hdl/egress_queue_scheduler.sv */
// egress queue scheduler for one port, with wishbone register slave
//
// Added by the designer: the address map and the Wishbone slave port.
module egress_queue_scheduler
	import egress_sched_pkg::*;
#(
	parameter int IN_PORTS = NUM_IN,
	parameter int CRED_W   = CREDIT_W
)
(
	// clock and reset
	input  wire logic                REF_CLK,
	input  wire logic                RESET_N,
	// wishbone slave
	input  wire logic                WB_CYC_I,
	input  wire logic                WB_STB_I,
	input  wire logic                WB_WE_I,
	input  wire logic [7:0]          WB_ADR_I,
	input  wire logic [3:0]          WB_SEL_I,
	input  wire logic [31:0]         WB_DAT_I,
	output logic      [31:0]         WB_DAT_O,
	output logic                     WB_ACK_O,
	// queue manager
	input  wire logic [NUM_Q-1:0]    Q_NONEMPTY,
	input  wire logic [NUM_Q-1:0]    SHAPER_OK,
	input  wire logic                ENQ_VALID,
	input  wire logic [LEN_W-1:0]    ENQ_LEN,
	input  wire logic [QW-1:0]       ENQ_TC,
	input  wire logic [7:0]          ENQ_REASON,
	input  wire logic                ENQ_TO_MGMT,
	input  wire logic [2:0]          ENQ_SRC_PORT,
	input  wire logic [2:0]          DEQ_SRC_PORT,
	output logic                     ENQ_QUEUE_VALID,
	output logic      [QW-1:0]       ENQ_QUEUE,
	// transmit mac
	output logic                     TX_REQ,
	output logic      [QW-1:0]       TX_QUEUE,
	input  wire logic                TX_DONE,
	input  wire logic [LEN_W-1:0]    TX_LEN
);
	if (CRED_W < CREDIT_W || IN_PORTS < 1 || IN_PORTS > 8)
	begin : g_bad
		$error("credit width or ingress port count not supported");
	end

	typedef logic signed [CRED_W-1:0] cred_t;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] val, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				r[b*8 +: 8] = val[b*8 +: 8];
		return r;
	endfunction

	function automatic logic [QW-1:0] top_bit(input logic [NUM_Q-1:0] v);
		logic [QW-1:0] r;
		r = '0;
		for (int i = 0; i < NUM_Q; i++)
			if (v[i])
				r = QW'(i);
		return r;
	endfunction

	function automatic logic [QW-1:0] map_of(input logic [23:0] m,
		input logic [QW-1:0] idx);
		return m[idx*QW +: QW];
	endfunction

	logic [5:0]             ctrl_reg;
	logic [31:0]            weight_lo_reg;
	logic [31:0]            weight_hi_reg;
	logic [23:0]            cpu_map_reg;
	logic [23:0]            tc2cos_reg;
	logic                   ack_reg;
	logic [31:0]            rdata_next;
	logic [OCC_W-1:0]       qocc_reg [NUM_Q];
	logic [OCC_W-1:0]       iocc_reg [IN_PORTS];
	logic [OCC_W-1:0]       iarr_reg [IN_PORTS];
	state_t                 state_reg;
	state_t                 state_next;
	logic [QW-1:0]          ptr_reg;
	logic [NUM_Q-1:0]       mask_reg;
	cred_t                  credit_reg [NUM_Q];
	logic                   rr_grant_reg;
	logic [QW-1:0]          cls_q;
	logic [NUM_Q-1:0]       sp_mask;
	logic [NUM_Q-1:0]       elig;
	logic [3:0]             sp_n;
	logic [2:0]             opt;
	logic                   byte_mode;
	logic                   burst_mode;
	logic                   wr_en;
	logic                   grant;
	logic                   grant_rr;
	logic [QW-1:0]          grant_q;
	logic                   drop_idle;
	logic                   post_drop;
	cred_t                  cost;
	logic [63:0]            weights;

	assign opt        = ctrl_reg[CTRL_OPT_LSB +: 3];
	assign byte_mode  = ctrl_reg[CTRL_BYTE_BIT];
	assign weights    = {weight_hi_reg, weight_lo_reg};
	assign burst_mode = ctrl_reg[CTRL_BURST_BIT];
	assign elig       = Q_NONEMPTY & SHAPER_OK;

	// strict queues are the top sp_n; options past the last act as all rr
	always_comb
	begin
		if (opt == 3'h0)
			sp_n = 4'h8;
		else if (opt < 3'(NUM_OPT - 1))
			sp_n = {1'b0, opt};
		else
			sp_n = 4'h0;
		for (int q = 0; q < NUM_Q; q++)
			sp_mask[q] = (q >= NUM_Q - int'(sp_n));
	end

	// wishbone: ack one cycle after the request, write on the ack edge
	assign wr_en = WB_CYC_I && WB_STB_I && WB_WE_I && ack_reg;

	always_ff @(posedge REF_CLK)
	begin
		if (!RESET_N)
			ack_reg <= 1'b0;
		else
			ack_reg <= WB_CYC_I && WB_STB_I && !ack_reg;
	end
	assign WB_ACK_O = ack_reg;

	always_ff @(posedge REF_CLK)
	begin
		if (!RESET_N)
		begin
			ctrl_reg      <= CTRL_RST;
			weight_lo_reg <= WEIGHT_RST;
			weight_hi_reg <= WEIGHT_RST;
			cpu_map_reg   <= MAP_RST;
			tc2cos_reg    <= MAP_RST;
		end
		else if (wr_en)
		begin
			unique case (WB_ADR_I)
				ADDR_CTRL:      ctrl_reg <= 6'(merge(32'(ctrl_reg),
					WB_DAT_I, WB_SEL_I));
				ADDR_WEIGHT_LO: weight_lo_reg <= merge(weight_lo_reg,
					WB_DAT_I, WB_SEL_I);
				ADDR_WEIGHT_HI: weight_hi_reg <= merge(weight_hi_reg,
					WB_DAT_I, WB_SEL_I);
				ADDR_CPU_MAP:   cpu_map_reg <= 24'(merge(32'(cpu_map_reg),
					WB_DAT_I, WB_SEL_I));
				ADDR_TC2COS:    tc2cos_reg <= 24'(merge(32'(tc2cos_reg),
					WB_DAT_I, WB_SEL_I));
				default: ;
			endcase
		end
	end

	// read mux; unmapped addresses read zero
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		unique case (WB_ADR_I)
			ADDR_CTRL:      rdata_next = 32'(ctrl_reg);
			ADDR_WEIGHT_LO: rdata_next = weight_lo_reg;
			ADDR_WEIGHT_HI: rdata_next = weight_hi_reg;
			ADDR_CPU_MAP:   rdata_next = 32'(cpu_map_reg);
			ADDR_TC2COS:    rdata_next = 32'(tc2cos_reg);
			ADDR_STATUS:
			begin
				rdata_next[STAT_BUSY_BIT] = TX_REQ;
				rdata_next[STAT_PTR_LSB +: QW] = ptr_reg;
				rdata_next[STAT_MASK_LSB +: NUM_Q] = mask_reg;
			end
			default:
			begin
				for (int q = 0; q < NUM_Q; q++)
					if (WB_ADR_I == ADDR_QOCC_BASE + 8'(4*q))
						rdata_next = 32'(qocc_reg[q]);
				for (int p = 0; p < IN_PORTS; p++)
				begin
					if (WB_ADR_I == ADDR_IN_BASE + 8'(8*p))
						rdata_next = 32'(iocc_reg[p]);
					if (WB_ADR_I == ADDR_IN_BASE + 8'(8*p + 4))
						rdata_next = 32'(iarr_reg[p]);
				end
			end
		endcase
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RESET_N)
			WB_DAT_O <= 32'h0000_0000;
		else if (WB_CYC_I && WB_STB_I && !WB_WE_I && !ack_reg)
			WB_DAT_O <= rdata_next;
	end

	// queue choice for an arriving frame
	always_comb
	begin
		if (ENQ_TO_MGMT && !ctrl_reg[CTRL_AGG_BIT])
			cls_q = map_of(cpu_map_reg, top_bit(ENQ_REASON));
		else
			cls_q = map_of(tc2cos_reg, ENQ_TC);
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RESET_N)
		begin
			ENQ_QUEUE_VALID <= 1'b0;
			ENQ_QUEUE       <= '0;
		end
		else
		begin
			ENQ_QUEUE_VALID <= ENQ_VALID;
			ENQ_QUEUE       <= cls_q;
		end
	end

	// occupancy: add on arrival, subtract on completed transmit
	always_ff @(posedge REF_CLK)
	begin
		for (int q = 0; q < NUM_Q; q++)
		begin
			if (!RESET_N)
				qocc_reg[q] <= '0;
			else
				qocc_reg[q] <= qocc_reg[q]
					+ ((ENQ_VALID && cls_q == QW'(q)) ? OCC_W'(ENQ_LEN) : '0)
					- ((TX_DONE && TX_QUEUE == QW'(q)) ? OCC_W'(TX_LEN) : '0);
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		for (int p = 0; p < IN_PORTS; p++)
		begin
			if (!RESET_N)
			begin
				iocc_reg[p] <= '0;
				iarr_reg[p] <= '0;
			end
			else
			begin
				iocc_reg[p] <= iocc_reg[p]
					+ ((ENQ_VALID && ENQ_SRC_PORT == 3'(p)) ?
						OCC_W'(ENQ_LEN) : '0)
					- ((TX_DONE && DEQ_SRC_PORT == 3'(p)) ?
						OCC_W'(TX_LEN) : '0);
				if (ENQ_VALID && ENQ_SRC_PORT == 3'(p))
					iarr_reg[p] <= iarr_reg[p] + OCC_W'(ENQ_LEN);
			end
		end
	end

	// decision in idle: strict first, then the round pointer
	always_comb
	begin
		grant      = 1'b0;
		grant_rr   = 1'b0;
		grant_q    = ptr_reg;
		drop_idle  = 1'b0;
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE:
			begin
				if (|(elig & sp_mask))
				begin
					grant   = 1'b1;
					grant_q = top_bit(elig & sp_mask);
				end
				else if (mask_reg == '0)
				begin
					if (|(Q_NONEMPTY & ~sp_mask))
						state_next = ST_START;
				end
				// a queue still in deficit sits out, keeping its debt
				else if (mask_reg[ptr_reg] && elig[ptr_reg]
					&& credit_reg[ptr_reg] >= 0)
				begin
					grant    = 1'b1;
					grant_rr = 1'b1;
				end
				else
					drop_idle = mask_reg[ptr_reg];
				if (grant)
					state_next = ST_WAIT;
			end
			ST_START: state_next = ST_IDLE;
			ST_WAIT:  if (TX_DONE) state_next = ST_POST;
			ST_POST:  state_next = ST_IDLE;
		endcase
	end

	assign cost = byte_mode ? cred_t'(TX_LEN) : cred_t'(1);
	assign post_drop = !Q_NONEMPTY[ptr_reg] || credit_reg[ptr_reg] < 0;

	always_ff @(posedge REF_CLK)
	begin
		if (!RESET_N)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RESET_N)
		begin
			TX_REQ       <= 1'b0;
			TX_QUEUE     <= '0;
			rr_grant_reg <= 1'b0;
		end
		else if (grant)
		begin
			TX_REQ       <= 1'b1;
			TX_QUEUE     <= grant_q;
			rr_grant_reg <= grant_rr;
		end
		else if (TX_DONE)
			TX_REQ <= 1'b0;
	end

	// round membership and pointer
	always_ff @(posedge REF_CLK)
	begin
		if (!RESET_N)
		begin
			mask_reg <= '0;
			ptr_reg  <= QW'(NUM_Q - 1);
		end
		else if (state_reg == ST_START)
		begin
			mask_reg <= Q_NONEMPTY & ~sp_mask;
			ptr_reg  <= QW'(NUM_Q - 1);
		end
		else if (state_reg == ST_IDLE && !grant && mask_reg != '0)
		begin
			if (drop_idle)
				mask_reg[ptr_reg] <= 1'b0;
			ptr_reg <= ptr_reg - 1'b1;
		end
		else if (state_reg == ST_POST && rr_grant_reg)
		begin
			if (post_drop)
				mask_reg[ptr_reg] <= 1'b0;
			if (post_drop || !burst_mode)
				ptr_reg <= ptr_reg - 1'b1;
		end
	end

	// credits: add share at round start, debit at completion
	always_ff @(posedge REF_CLK)
	begin
		for (int q = 0; q < NUM_Q; q++)
		begin
			if (!RESET_N)
				credit_reg[q] <= '0;
			else if (state_reg == ST_START && !sp_mask[q])
			begin
				if (!Q_NONEMPTY[q])
					credit_reg[q] <= '0;
				else if (byte_mode)
					credit_reg[q] <= credit_reg[q] + cred_t'(
						32'(weights[q*8 +: WEIGHT_W]) * BYTE_UNIT);
				else
					credit_reg[q] <= credit_reg[q]
						+ cred_t'(weights[q*8 +: WEIGHT_W]);
			end
			else if (state_reg == ST_WAIT && TX_DONE && rr_grant_reg
				&& TX_QUEUE == QW'(q))
				credit_reg[q] <= credit_reg[q] - cost;
			// unused share of a skipped queue is dropped so it cannot pile up
			else if (q == int'(ptr_reg)
				&& ((state_reg == ST_POST && rr_grant_reg) || drop_idle)
				&& (!Q_NONEMPTY[q] || (drop_idle && credit_reg[q] > 0)))
				credit_reg[q] <= '0;
		end
	end

	// checks
	property p_sp_first;
		@(posedge REF_CLK) disable iff (!RESET_N)
		(state_reg == ST_IDLE && |(elig & sp_mask))
			|=> TX_REQ && TX_QUEUE == $past(top_bit(elig & sp_mask));
	endproperty
	a_sp_first: assert property (p_sp_first)
		else $error("strict queue not served first");

	property p_hold;
		@(posedge REF_CLK) disable iff (!RESET_N)
		(TX_REQ && !TX_DONE) |=> TX_REQ && $stable(TX_QUEUE);
	endproperty
	a_hold: assert property (p_hold)
		else $error("grant changed before completion");

	property p_debit;
		@(posedge REF_CLK) disable iff (!RESET_N)
		(state_reg == ST_WAIT && TX_DONE && rr_grant_reg)
			|=> credit_reg[TX_QUEUE] == $past(credit_reg[TX_QUEUE]) - $past(cost);
	endproperty
	a_debit: assert property (p_debit)
		else $error("credit not debited at completion");

	property p_empty_zero;
		@(posedge REF_CLK) disable iff (!RESET_N)
		(state_reg == ST_POST && rr_grant_reg && !Q_NONEMPTY[ptr_reg])
			|=> credit_reg[$past(ptr_reg)] == 0 && !mask_reg[$past(ptr_reg)];
	endproperty
	a_empty_zero: assert property (p_empty_zero)
		else $error("emptied queue kept credit");

	property p_start_excl;
		@(posedge REF_CLK) disable iff (!RESET_N)
		state_reg == ST_START |=> (mask_reg & ~$past(Q_NONEMPTY)) == '0;
	endproperty
	a_start_excl: assert property (p_start_excl)
		else $error("empty queue joined the round");

	property p_once;
		@(posedge REF_CLK) disable iff (!RESET_N)
		state_reg != ST_START |=> (mask_reg & ~$past(mask_reg)) == '0;
	endproperty
	a_once: assert property (p_once)
		else $error("queue rejoined the round");

	property p_eligible;
		@(posedge REF_CLK) disable iff (!RESET_N)
		grant |-> elig[grant_q] ##1 TX_QUEUE == $past(grant_q);
	endproperty
	a_eligible: assert property (p_eligible)
		else $error("ineligible queue granted");

	property p_cpu_map;
		@(posedge REF_CLK) disable iff (!RESET_N)
		(ENQ_VALID && ENQ_TO_MGMT && !ctrl_reg[CTRL_AGG_BIT] && ENQ_REASON[7])
			|=> ENQ_QUEUE == cpu_map_reg[21 +: 3];
	endproperty
	a_cpu_map: assert property (p_cpu_map)
		else $error("cpu queue not from top reason");

	property p_occ;
		@(posedge REF_CLK) disable iff (!RESET_N)
		(ENQ_VALID && !TX_DONE) |=>
			qocc_reg[$past(cls_q)] == $past(qocc_reg[cls_q]) + $past(ENQ_LEN);
	endproperty
	a_occ: assert property (p_occ)
		else $error("occupancy not raised on arrival");

	c_round: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
		state_reg == ST_START ##[1:200] state_reg == ST_START);
	c_neg: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
		state_reg == ST_POST && credit_reg[ptr_reg] < 0 && Q_NONEMPTY[ptr_reg]);
	c_sp_pre: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
		grant && !grant_rr && mask_reg != '0);
endmodule

/* dv/mac_queue_model.sv */
// queue manager and transmit mac stand-in for the scheduler bench
module mac_queue_model
	import egress_sched_pkg::*;
(
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	// bench control
	input  wire logic                         load,
	input  wire logic [NUM_Q-1:0][3:0]        load_cnt,
	input  wire logic [NUM_Q-1:0][LEN_W-1:0]  load_len,
	input  wire logic                         slow,
	// scheduler side
	output logic      [NUM_Q-1:0]             q_nonempty,
	input  wire logic                         tx_req,
	input  wire logic [QW-1:0]                tx_queue,
	output logic                              tx_done,
	output logic      [LEN_W-1:0]             tx_len,
	output logic      [2:0]                   deq_src
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [NUM_Q-1:0][3:0]       cnt;
	logic [NUM_Q-1:0][LEN_W-1:0] len;
	logic                        busy;
	logic [2:0]                  wait_c;
	always_comb
	begin
		for (int i = 0; i < NUM_Q; i++)
			q_nonempty[i] = (cnt[i] != 4'h0);
	end
	// length and source only meaningful with done
	assign tx_len  = tx_done ? len[tx_queue] : ~len[tx_queue];
	assign deq_src = tx_done ? 3'h1 : 3'h6;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt     <= '0;
			busy    <= 1'b0;
			tx_done <= 1'b0;
			wait_c  <= 3'h0;
		end
		else
		begin
			if (load)
			begin
				cnt <= load_cnt;
				len <= load_len;
			end
			if (tx_done)
			begin
				tx_done       <= 1'b0;
				busy          <= 1'b0;
				cnt[tx_queue] <= cnt[tx_queue] - 4'h1;
			end
			else if (tx_req && !busy)
			begin
				busy   <= 1'b1;
				wait_c <= slow ? 3'h5 : 3'h1;
			end
			else if (busy && wait_c > 3'h1)
				wait_c <= wait_c - 3'h1;
			else if (busy)
				tx_done <= 1'b1;
		end
	end
endmodule

/* dv/testbench.sv */
// self-checking bench for the egress queue scheduler
module testbench
	import egress_sched_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 clk, rst_n, cyc, stb, we, ack;
	logic [7:0]           adr, reason, q_ne, shp;
	logic [3:0]           sel;
	logic [31:0]          wdat, rdat, r;
	logic                 enq_v, enq_mgmt, enq_qv, tx_req, tx_done;
	logic                 load, slow;
	logic [LEN_W-1:0]     enq_len, tx_len;
	logic [2:0]           enq_tc, enq_src, deq_src, enq_q, tx_q;
	logic [7:0][3:0]      c;
	logic [7:0][13:0]     l;
	int                   failures, comparisons;
	logic [2:0]           got [$];
	egress_queue_scheduler DUT (.REF_CLK(clk), .RESET_N(rst_n),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.Q_NONEMPTY(q_ne), .SHAPER_OK(shp), .ENQ_VALID(enq_v),
		.ENQ_LEN(enq_len), .ENQ_TC(enq_tc), .ENQ_REASON(reason),
		.ENQ_TO_MGMT(enq_mgmt), .ENQ_SRC_PORT(enq_src),
		.DEQ_SRC_PORT(deq_src), .ENQ_QUEUE_VALID(enq_qv),
		.ENQ_QUEUE(enq_q), .TX_REQ(tx_req), .TX_QUEUE(tx_q),
		.TX_DONE(tx_done), .TX_LEN(tx_len));
	mac_queue_model far (.clk(clk), .rst_n(rst_n), .load(load),
		.load_cnt(c), .load_len(l), .slow(slow), .q_nonempty(q_ne),
		.tx_req(tx_req), .tx_queue(tx_q), .tx_done(tx_done),
		.tx_len(tx_len), .deq_src(deq_src));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk)
		if (tx_done === 1'b1)
			got.push_back(tx_q);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		sel  <= s;
		@(posedge clk);
		while (ack !== 1'b1)
			@(posedge clk);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, 4'hF);
		check(r, e);
	endtask
	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		got.delete();
	endtask
	task automatic fill();
		load <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
		c    <= '0;
	endtask
	task automatic cmp_seq(input logic [2:0] e [$]);
		int k;
		k = 0;
		while (got.size() < e.size() && k < 4000)
		begin
			@(posedge clk);
			k++;
		end
		repeat (30) @(posedge clk);
		check(got.size(), e.size());
		foreach (got[i])
			if (i < e.size())
				check(got[i], e[i]);
		got.delete();
	endtask
	task automatic enq(input logic m, input logic [7:0] rs,
		input logic [2:0] tc, input logic [13:0] ln, input logic [2:0] e);
		enq_mgmt <= m;
		reason   <= rs;
		enq_tc   <= tc;
		enq_len  <= ln;
		enq_v    <= 1'b1;
		@(posedge clk);
		enq_v <= 1'b0;
		@(posedge clk);
		check(enq_qv, 1'b1);
		check(enq_q, e);
		@(posedge clk);
		check(enq_qv, 1'b0);
	endtask
	task automatic t_regs();
		do_reset();
		rdchk(ADDR_CTRL, {26'h0, CTRL_RST});
		rdchk(ADDR_WEIGHT_LO, WEIGHT_RST);
		rdchk(ADDR_CPU_MAP, {8'h00, MAP_RST});
		rdchk(ADDR_TC2COS, {8'h00, MAP_RST});
		rdchk(ADDR_STATUS, 32'h0000000E);
		wb(1'b1, ADDR_WEIGHT_HI, 32'hAABBCCDD, 4'h2);
		rdchk(ADDR_WEIGHT_HI, 32'h0101CC01);
		wb(1'b1, 8'hF0, 32'h12345678, 4'hF);
		rdchk(8'hF0, 32'h0);
		$display("registers done");
	endtask
	task automatic t_enq();
		logic [31:0] m;
		do_reset();
		m = '0;
		for (int i = 0; i < 8; i++)
			m[3*i +: 3] = 3'(7 - i);
		wb(1'b1, ADDR_CPU_MAP, m, 4'hF);
		enq(1'b1, 8'h26, 3'h1, 14'h064, 3'h2);
		enq(1'b0, 8'h80, 3'h3, 14'h050, 3'h3);
		enq(1'b1, 8'h81, 3'h4, 14'h010, 3'h0);
		wb(1'b1, ADDR_CTRL, 32'h20, 4'hF);
		enq(1'b1, 8'h01, 3'h6, 14'h03C, 3'h6);
		rdchk(ADDR_QOCC_BASE + 8'h08, 32'h64);
		rdchk(ADDR_QOCC_BASE + 8'h0C, 32'h50);
		rdchk(ADDR_QOCC_BASE, 32'h10);
		rdchk(ADDR_IN_BASE + 8'h10, 32'h100);
		rdchk(ADDR_IN_BASE + 8'h14, 32'h100);
		$display("enqueue done");
	endtask
	task automatic t_sched();
		do_reset();
		l    <= {8{14'h040}};
		c[7] <= 4'h1;
		c[5] <= 4'h2;
		c[2] <= 4'h1;
		fill();
		cmp_seq('{3'h7, 3'h5, 3'h5, 3'h2});
		do_reset();
		wb(1'b1, ADDR_CTRL, 32'h02, 4'hF);
		shp <= 8'hEF;
		c[6] <= 4'h2;
		c[4] <= 4'h1;
		c[3] <= 4'h2;
		fill();
		cmp_seq('{3'h6, 3'h6, 3'h3, 3'h3});
		shp <= 8'hFF;
		cmp_seq('{3'h4});
		do_reset();
		wb(1'b1, ADDR_CTRL, 32'h05, 4'hF);
		wb(1'b1, ADDR_WEIGHT_HI, 32'h02020101, 4'hF);
		c[7] <= 4'h3;
		c[6] <= 4'h3;
		fill();
		cmp_seq('{3'h7, 3'h6, 3'h7, 3'h6, 3'h7, 3'h6});
		$display("priority and packet round robin done");
	endtask
	task automatic t_wdrr();
		do_reset();
		slow <= 1'b1;
		wb(1'b1, ADDR_CTRL, 32'h1D, 4'hF);
		wb(1'b1, ADDR_WEIGHT_LO, 32'h04030201, 4'hF);
		l[3] <= 14'h07B;
		l[1] <= 14'h0FA;
		l[0] <= 14'h064;
		c[3] <= 4'h2;
		c[1] <= 4'h6;
		c[0] <= 4'h5;
		fill();
		cmp_seq('{3'h3, 3'h3, 3'h1, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0,
			3'h1, 3'h1, 3'h0, 3'h0, 3'h1});
		slow <= 1'b0;
		$display("byte round robin done");
	endtask
	task automatic tally_and_finish();
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		tally_and_finish();
	end
	initial
	begin
		failures = 0; comparisons = 0;
		rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
		sel = 4'h0; wdat = 32'h0; shp = 8'hFF; enq_v = 1'b0;
		enq_mgmt = 1'b0; reason = 8'h00; enq_tc = 3'h0; enq_len = '0;
		enq_src = 3'h2; load = 1'b0; slow = 1'b0; c = '0; l = '0;
		@(posedge clk);
		t_regs();
		t_enq();
		t_sched();
		t_wdrr();
		tally_and_finish();
	end
endmodule
